// ==== dv/can_acceptance_filter_config_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module can_acceptance_filter_config_tb;
  import can_filter_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  // mask 0 compares all, 1 nothing, 2 extended bits only, 3 standard bits only
  mask_set_t masks = {29'h1FFC0000, 29'h0003FFFF, 29'h00000000, 29'h1FFFFFFF};
  logic rx_valid, rx_ide, match_valid, match_hit;
  logic [10:0] rx_standard_ident;
  logic [17:0] rx_extended_ident;
  logic [3:0] match_filter;
  logic [4:0] match_fifo;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  always #4 mclk = ~mclk;
  can_acceptance_filter_config u_can_acceptance_filter_config (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .masks(masks), .rx_valid(rx_valid),
    .rx_ide(rx_ide), .rx_standard_ident(rx_standard_ident),
    .rx_extended_ident(rx_extended_ident), .match_valid(match_valid),
    .match_hit(match_hit), .match_filter(match_filter), .match_fifo(match_fifo));
  can_rx_engine_model u_can_rx_engine_model (
    .mclk(mclk), .rx_valid(rx_valid), .rx_ide(rx_ide),
    .rx_standard_ident(rx_standard_ident), .rx_extended_ident(rx_extended_ident));
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask
  // the match result is registered off the edge that took rx_valid
  task automatic msg(input logic ide, input logic [10:0] std_id, input logic [17:0] ext_id,
                     input logic hit, input logic [3:0] filt, input logic [4:0] fifo);
    u_can_rx_engine_model.send(ide, std_id, ext_id);
    #1;
    chk({21'h0, match_valid, match_hit, match_filter, match_fifo},
        {21'h0, 1'b1, hit, filt, fifo});
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h7C, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h90, 32'h0);
    $display("test reset values done");
    wr(8'h0C, 32'h7F0F6A25);
    rd(8'h0C, 32'h7F0F6A25);
    wr(8'h74, 32'hFFFFFFFF);
    rd(8'h74, 32'hFFEBFFFF);
    wr(8'h0C, 32'h00800000);
    wr(8'h0C, 32'h00600000);
    rd(8'h0C, 32'h00000000);
    $display("test packing done");
    wr(8'h40, 32'h24600000);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, {24'h0, 1'b1, 2'(k), 5'(k + 3)});
      // receive standard id 0x122 against filter id 0x123
      msg(1'b0, 11'h122, 18'h3FFFF, k == 1 || k == 2, 4'h0,
          (k == 1 || k == 2) ? 5'(k + 3) : 5'h00);
    end
    $display("test mask choice done");
    wr(8'h00, 32'h0);
    wr(8'h44, 32'hAAAAAAAA);
    wr(8'h00, 32'h00008F00);
    u_can_rx_engine_model.idle_cycles = 3;
    msg(1'b1, 11'h555, 18'h2AAAA, 1'b1, 4'h1, 5'h0F);
    u_can_rx_engine_model.idle_cycles = 0;
    msg(1'b0, 11'h555, 18'h2AAAA, 1'b0, 4'h0, 5'h00);
    msg(1'b1, 11'h555, 18'h2AAAB, 1'b0, 4'h0, 5'h00);
    msg(1'b1, 11'h554, 18'h2AAAA, 1'b0, 4'h0, 5'h00);
    $display("test extended frames done");
    wr(8'h00, 32'h0000E200);
    rd(8'h00, 32'h00008F00);
    wr(8'h44, 32'h0);
    rd(8'h44, 32'hAAAAAAAA);
    wr(8'h00, 32'h00006200);
    rd(8'h00, 32'h00000F00);
    msg(1'b1, 11'h555, 18'h2AAAA, 1'b0, 4'h0, 5'h00);
    $display("test locked filter done");
    wr(8'h00, 32'h00009000);
    msg(1'b1, 11'h555, 18'h2AAAA, 1'b0, 4'h0, 5'h00);
    rd(8'h00, 32'h00009000);
    rd(8'h80, 32'h00030000);
    $display("test reserved fifo done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== dv/can_rx_engine_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module can_rx_engine_model (
  input wire logic mclk, // bench clock
  output logic rx_valid, // one pulse per message
  output logic rx_ide, // extended frame flag
  output logic [10:0] rx_standard_ident, // standard id
  output logic [17:0] rx_extended_ident // extended id
);
  int idle_cycles = 0; // above zero models a slow bus
  initial begin
    rx_valid = 1'b0;
    rx_ide = 1'b0;
    rx_standard_ident = 11'h000;
    rx_extended_ident = 18'h00000;
  end
  // ids mean nothing once rx_valid drops; flip them so stale values cannot match
  task automatic send(input logic ide, input logic [10:0] std_id,
                      input logic [17:0] ext_id);
    repeat (idle_cycles) @(posedge mclk);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_ide <= ide;
    rx_standard_ident <= std_id;
    rx_extended_ident <= ext_id;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_ide <= ~ide;
    rx_standard_ident <= ~std_id;
    rx_extended_ident <= ~ext_id;
  endtask
endmodule
`default_nettype wire

// ==== verilog/can_acceptance_filter_config.sv ====
// Function
// [RULE1] a filter takes part in acceptance only while its enable bit is set
// [RULE2] two-bit mask choice picks acceptance mask 0 to 3
// [RULE3] five-bit fifo target picks fifo 0 to 15; codes 16 to 31 reserved
// [RULE4] enable, mask and fifo settings change only while filter disabled; here the enable bit can still be written while enabled
// [RULE5] control word: one filter per byte lane, enable, mask, fifo from top
// [RULE6] identifier word: standard id 31-21, frame select 19 (reset 0), extended id 17-0
// [RULE7] standard id bits must equal filter bits where the mask compares
// [RULE8] frame select 1 matches extended frames only, 0 standard only
// [RULE9] extended frames: extended id bits must match under the mask
// [RULE10] identifier word written only while its filter is disabled
// [RULE11] writes to locked fields of an enabled filter are ignored
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "can_filter_defines.svh"
module can_acceptance_filter_config (
  input wire logic mclk, // 125 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [`ADDR_W-1:0] addr, // register byte address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [31:0] rd_data, // read data, cycle after rd_en
  input wire can_filter_pkg::mask_set_t masks, // acceptance masks, 1 = compare
  input wire logic rx_valid, // received identifier present
  input wire logic rx_ide, // received frame is extended
  input wire logic [10:0] rx_standard_ident, // received standard id
  input wire logic [17:0] rx_extended_ident, // received extended id
  output logic match_valid, // pulse, one cycle after rx_valid
  output logic match_hit, // some filter accepted
  output logic [3:0] match_filter, // accepting filter number
  output logic [4:0] match_fifo // destination fifo
);
  import can_filter_pkg::*;

  typedef struct packed {
    filter_cfg_s [`NUM_FILTERS-1:0] cfg;
    filter_ident_s [`NUM_FILTERS-1:0] ident;
    logic [31:0] rd_data;
    logic match_valid;
    logic match_hit;
    logic [`FILT_IDX_W-1:0] match_filter;
    logic [`FIFO_IDX_W-1:0] match_fifo;
    logic [`COUNT_W-1:0] accept_count;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic ctrl_sel;
  logic ident_sel;
  logic status_sel;
  logic [1:0] ctrl_word;
  logic [3:0] ident_idx;
  logic [`NUM_FILTERS-1:0] hit_vec;
  logic [`NUM_FILTERS-1:0] on_vec;
  logic [`NUM_FILTERS-1:0] xsel_vec;
  logic any_hit;
  logic [`FILT_IDX_W-1:0] pick_idx;

  ////////////////////////////////////////////////////////////////////////
  // address decode; the two low address bits are ignored

  assign ctrl_sel = (addr[7:4] == `CTRL_PAGE);
  assign ident_sel = (addr[7:6] == `IDENT_PAGE);
  assign status_sel = ({addr[7:2], 2'b00} == `STATUS_ADDR);
  assign ctrl_word = addr[3:2];
  assign ident_idx = addr[5:2];

  ////////////////////////////////////////////////////////////////////////
  // one comparator per filter, lowest number wins

  for (genvar g = 0; g < `NUM_FILTERS; g++) begin : g_filt
    filter_compare u_cmp (
      .filter_on(st_reg.cfg[g].filter_on),
      .mask_choice(st_reg.cfg[g].mask_choice),
      .fifo_target(st_reg.cfg[g].fifo_target),
      .standard_ident(st_reg.ident[g].standard_ident),
      .extended_frame_select(st_reg.ident[g].extended_frame_select),
      .extended_ident(st_reg.ident[g].extended_ident),
      .masks(masks),
      .rx_ide(rx_ide),
      .rx_standard_ident(rx_standard_ident),
      .rx_extended_ident(rx_extended_ident),
      .hit(hit_vec[g])
    );
    assign on_vec[g] = st_reg.cfg[g].filter_on;
    assign xsel_vec[g] = st_reg.ident[g].extended_frame_select;
  end

  first_hit_picker #(
    .N(`NUM_FILTERS),
    .W(`FILT_IDX_W)
  ) u_pick (
    .hits(hit_vec),
    .found(any_hit),
    .index(pick_idx)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [`LANE_W-1:0] lane;
    st_next = st_reg;
    lane = '0;
    st_next.rd_data = '0;
    if (wr_en && ctrl_sel) begin
      for (int f = 0; f < `NUM_FILTERS; f++) begin
        if (f / `LANES_PER_WORD == int'(ctrl_word)) begin
          lane = wr_data[(f % `LANES_PER_WORD) * `LANE_W +: `LANE_W]; // [RULE5]
          if (!st_reg.cfg[f].filter_on) begin
            st_next.cfg[f] = filter_cfg_s'(lane); // [RULE4]
          end else begin
            // only the enable may move, so software can still switch it off
            st_next.cfg[f].filter_on = lane[`ON_BIT]; // [RULE11]
          end
        end
      end
    end
    if (wr_en && ident_sel && !st_reg.cfg[ident_idx].filter_on) begin // [RULE10]
      st_next.ident[ident_idx].standard_ident = wr_data[`STD_HI:`STD_LO]; // [RULE6]
      st_next.ident[ident_idx].extended_frame_select = wr_data[`XSEL_BIT];
      st_next.ident[ident_idx].extended_ident = wr_data[`EXT_HI:`EXT_LO];
    end
    if (rd_en) begin
      if (ctrl_sel) begin
        st_next.rd_data = st_reg.cfg[ctrl_word * `LANES_PER_WORD +: `LANES_PER_WORD];
      end else if (ident_sel) begin
        // unimplemented bits 20 and 18 read as zero
        st_next.rd_data = {st_reg.ident[ident_idx].standard_ident, 1'b0, // [RULE6]
                           st_reg.ident[ident_idx].extended_frame_select, 1'b0,
                           st_reg.ident[ident_idx].extended_ident};
      end else if (status_sel) begin
        st_next.rd_data = {st_reg.accept_count, 3'h0, st_reg.match_hit,
                           st_reg.match_filter, 3'h0, st_reg.match_fifo};
      end
    end
    st_next.match_valid = rx_valid;
    if (rx_valid) begin
      st_next.match_hit = any_hit; // [RULE1]
      st_next.match_filter = any_hit ? pick_idx : '0;
      st_next.match_fifo = any_hit ? st_reg.cfg[pick_idx].fifo_target : '0; // [RULE3]
      if (any_hit) begin
        st_next.accept_count = st_reg.accept_count + `COUNT_W'(1);
      end
    end
  end

  // identifier fields have no defined power-up value; they clear to zero here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign match_valid = st_reg.match_valid;
  assign match_hit = st_reg.match_hit;
  assign match_filter = st_reg.match_filter;
  assign match_fifo = st_reg.match_fifo;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic [28:0] mask0;
  assign mask0 = masks[st_reg.cfg[0].mask_choice];

  sequence s_ident_wr_locked;
    wr_en && ident_sel && st_reg.cfg[ident_idx].filter_on;
  endsequence

  sequence s_ident_wr_open0;
    wr_en && ident_sel && (ident_idx == 4'h0) && !st_reg.cfg[0].filter_on;
  endsequence

  property p_ident_locked;
    s_ident_wr_locked |=> (st_reg.ident == $past(st_reg.ident));
  endproperty
  a_ident_locked: assert property (p_ident_locked) // [RULE11]
    else $error("identifier changed while filter enabled");

  property p_ident_open;
    s_ident_wr_open0 |=> (st_reg.ident[0].standard_ident == $past(wr_data[31:21]))
      && (st_reg.ident[0].extended_frame_select == $past(wr_data[19]))
      && (st_reg.ident[0].extended_ident == $past(wr_data[17:0]));
  endproperty
  a_ident_open: assert property (p_ident_open) // [RULE10]
    else $error("identifier write to disabled filter not stored");

  property p_ctrl_lane12;
    wr_en && ctrl_sel && (ctrl_word == 2'h3) && !st_reg.cfg[12].filter_on
      |=> (st_reg.cfg[12] == $past(wr_data[7:0]))
      && ($past(st_reg.cfg[13].filter_on) || st_reg.cfg[13] == $past(wr_data[15:8]));
  endproperty
  a_ctrl_lane12: assert property (p_ctrl_lane12) // [RULE5]
    else $error("control lane not stored in its byte lane");

  property p_ctrl_locked;
    wr_en && ctrl_sel && (ctrl_word == 2'h3) && st_reg.cfg[14].filter_on
      |=> $stable(st_reg.cfg[14].mask_choice) && $stable(st_reg.cfg[14].fifo_target)
      && (st_reg.cfg[14].filter_on == $past(wr_data[23]));
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked) // [RULE4]
    else $error("mask or fifo changed while filter enabled");

  property p_all_off;
    rx_valid && (on_vec == '0) |=> match_valid && !match_hit;
  endproperty
  a_all_off: assert property (p_all_off) // [RULE1]
    else $error("message accepted with every filter disabled");

  property p_fifo_range;
    match_valid && match_hit |-> (match_fifo <= `FIFO_LAST);
  endproperty
  a_fifo_range: assert property (p_fifo_range) // [RULE3]
    else $error("message sent to reserved fifo");

  property p_frame_kind;
    rx_valid && ((xsel_vec & on_vec) == on_vec) && !rx_ide |=> match_valid && !match_hit;
  endproperty
  a_frame_kind: assert property (p_frame_kind) // [RULE8]
    else $error("standard frame accepted by extended-only filters");

  property p_std_mask;
    rx_valid && hit_vec[0]
      |-> (((rx_standard_ident ^ st_reg.ident[0].standard_ident)
      & mask0[`MASK_STD_HI:`MASK_STD_LO]) == '0);
  endproperty
  a_std_mask: assert property (p_std_mask) // [RULE7] [RULE2]
    else $error("standard id mismatch under selected mask");

  property p_ext_mask;
    rx_valid && rx_ide && any_hit
      |-> (((rx_extended_ident ^ st_reg.ident[pick_idx].extended_ident)
      & masks[st_reg.cfg[pick_idx].mask_choice][`MASK_EXT_HI:`MASK_EXT_LO]) == '0);
  endproperty
  a_ext_mask: assert property (p_ext_mask) // [RULE9]
    else $error("extended id mismatch under selected mask");

  property p_ident_read;
    rd_en && ident_sel |=> (rd_data[20] == 1'b0) && (rd_data[18] == 1'b0)
      ##1 (rd_data == '0) || $past(rd_en);
  endproperty
  a_ident_read: assert property (p_ident_read) // [RULE6]
    else $error("unimplemented identifier bits read nonzero");

  sequence s_rd_ctrl0;
    rd_en && ctrl_sel && (ctrl_word == 2'h0);
  endsequence

  property p_read_cfg0;
    s_rd_ctrl0 |=> (rd_data[`LANE_W-1:0] == $past(st_reg.cfg[0]));
  endproperty
  a_read_cfg0: assert property (p_read_cfg0) // [RULE5]
    else $error("filter 0 control lane read back wrong");

  property p_match_pulse;
    rx_valid |=> match_valid;
  endproperty
  a_match_pulse: assert property (p_match_pulse)
    else $error("no match result after received identifier");

  property p_match_idle;
    !rx_valid |=> !match_valid;
  endproperty
  a_match_idle: assert property (p_match_idle)
    else $error("match result without received identifier");

  property p_result_hold;
    !rx_valid |=> $stable(match_hit) && $stable(match_filter) && $stable(match_fifo);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("match result changed with no received identifier");

  property p_rd_idle;
    !rd_en |=> (rd_data == '0);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared after its cycle");

  property p_off_silent;
    (hit_vec & ~on_vec) == '0;
  endproperty
  a_off_silent: assert property (p_off_silent) // [RULE1]
    else $error("disabled filter reported a hit");

  property p_reserved_fifo;
    (st_reg.cfg[1].fifo_target > `FIFO_LAST) |-> !hit_vec[1];
  endproperty
  a_reserved_fifo: assert property (p_reserved_fifo) // [RULE3]
    else $error("filter with reserved fifo code reported a hit");

  property p_frame_match;
    any_hit |-> (st_reg.ident[pick_idx].extended_frame_select == rx_ide);
  endproperty
  a_frame_match: assert property (p_frame_match) // [RULE8]
    else $error("accepting filter has the other frame kind");

  property p_first_wins;
    rx_valid && hit_vec[0] |=> match_hit && (match_filter == '0);
  endproperty
  a_first_wins: assert property (p_first_wins)
    else $error("filter 0 hit but not reported first");

endmodule
`default_nettype wire

// ==== verilog/can_filter_defines.svh ====
`ifndef CAN_FILTER_DEFINES_SVH
`define CAN_FILTER_DEFINES_SVH

// filter count and bus geometry
`define NUM_FILTERS 16
`define ADDR_W 8
`define LANE_W 8
`define LANES_PER_WORD 4
`define FIFO_IDX_W 5
`define FILT_IDX_W 4
`define COUNT_W 16

// address map, byte addresses, one word per register
`define CTRL_PAGE 4'h0
`define IDENT_PAGE 2'h1
`define STATUS_ADDR 8'h80

// control lane layout
`define ON_BIT 7

// identifier word layout
`define STD_HI 31
`define STD_LO 21
`define XSEL_BIT 19
`define EXT_HI 17
`define EXT_LO 0

// mask word layout: {standard bits, extended bits}
`define MASK_STD_HI 28
`define MASK_STD_LO 18
`define MASK_EXT_HI 17
`define MASK_EXT_LO 0

// highest fifo code that is not reserved
`define FIFO_LAST 5'h0F

`endif

// ==== verilog/can_filter_pkg.sv ====
`default_nettype none
`include "can_filter_defines.svh"
package can_filter_pkg;

  // one control byte lane: enable on top, mask choice, fifo target below
  typedef struct packed {
    logic filter_on;
    logic [1:0] mask_choice;
    logic [4:0] fifo_target;
  } filter_cfg_s;

  typedef struct packed {
    logic [10:0] standard_ident;
    logic extended_frame_select;
    logic [17:0] extended_ident;
  } filter_ident_s;

  typedef logic [28:0] mask_t;
  typedef mask_t [3:0] mask_set_t;

endpackage
`default_nettype wire

// ==== verilog/filter_compare.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "can_filter_defines.svh"
module filter_compare (
  input wire logic filter_on, // filter enabled
  input wire logic [1:0] mask_choice, // selects one of four masks
  input wire logic [4:0] fifo_target, // destination fifo code
  input wire logic [10:0] standard_ident, // filter standard id
  input wire logic extended_frame_select, // 1 = extended frames only
  input wire logic [17:0] extended_ident, // filter extended id
  input wire can_filter_pkg::mask_set_t masks, // acceptance masks, 1 = compare
  input wire logic rx_ide, // received frame is extended
  input wire logic [10:0] rx_standard_ident, // received standard id
  input wire logic [17:0] rx_extended_ident, // received extended id
  output logic hit // filter accepts the message
);
  import can_filter_pkg::*;

  mask_t sel_mask;
  logic std_ok;
  logic ext_ok;

  always_comb begin
    sel_mask = masks[mask_choice]; // [RULE2]
    std_ok = ((rx_standard_ident ^ standard_ident)
             & sel_mask[`MASK_STD_HI:`MASK_STD_LO]) == '0; // [RULE7]
    ext_ok = !rx_ide || (((rx_extended_ident ^ extended_ident)
             & sel_mask[`MASK_EXT_HI:`MASK_EXT_LO]) == '0); // [RULE9]
    // a reserved fifo code has nowhere to store the message, so it never hits
    hit = filter_on // [RULE1]
          && (fifo_target <= `FIFO_LAST) // [RULE3]
          && (extended_frame_select == rx_ide) // [RULE8]
          && std_ok && ext_ok;
  end

endmodule
`default_nettype wire

// ==== verilog/first_hit_picker.sv ====
`timescale 1ns/1ns
`default_nettype none
module first_hit_picker #(
  parameter int N = 16, // number of candidates
  parameter int W = 4 // index width
) (
  input wire logic [N-1:0] hits, // one bit per candidate
  output logic found, // any bit set
  output logic [W-1:0] index // lowest set bit
);

  // lowest number wins so that priority is fixed and needs no state
  always_comb begin
    found = |hits;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hits[i]) begin
        index = W'(i);
      end
    end
  end

endmodule
`default_nettype wire
